// *** rtl/vtag_consts.svh ***
`ifndef VTAG_CONSTS_SVH
`define VTAG_CONSTS_SVH
// Behaviour
// - read multiple blocks 23h returns 32-bit words
// - request: flags, code, UID, first, count, CRC
// - block count field is blocks minus one
// - at most 64 blocks per read
// - running block address wraps from 63 to 0
// - option flag prefixes lock byte per block
// - lock byte bit0 locked, bits 7..1 zero
// - read error: flags, code 10h or 0Fh, CRC
// - select 25h with own UID selects, answers
// - select other UID: selected falls to ready, silent
// - select errors only when UID matches
// - plain success reply is flags plus CRC
// - reset to ready 26h returns to ready
// - addressed reset errors only on own UID
// - write AFI 27h stores AFI byte
// - AFI write errors 12h locked, 13h failed
// - lock AFI 28h locks AFI permanently
// - lock errors 11h already, 14h not taken

// ============================================================
// command codes
`define CMD_READ_MULTI  8'h23
`define CMD_SELECT      8'h25
`define CMD_RESET_READY 8'h26
`define CMD_WRITE_AFI   8'h27
`define CMD_LOCK_AFI    8'h28
// ============================================================
// request flag bits
`define FLAG_SELECT_BIT  4
`define FLAG_ADDRESS_BIT 5
`define FLAG_OPTION_BIT  6
// ============================================================
// error codes and response flags
`define ERR_OTHER      8'h0F
`define ERR_NO_BLOCK   8'h10
`define ERR_LOCKED_ALR 8'h11
`define ERR_LOCKED     8'h12
`define ERR_NOT_PROG   8'h13
`define ERR_NOT_LOCKED 8'h14
`define RESP_OK        8'h00
`define RESP_ERR       8'h01
// ============================================================
// memory and crc
`define NUM_BLOCKS     64
`define CRC_PRESET     16'hFFFF
`define CRC_POLY_REV   16'h8408
`define CRC_RESIDUE    16'hF0B8
// ============================================================
// timing
`define CLK_PERIOD_PS        4000
`define NOMINAL_REPLY_NS     318550
`define PROG_SLOT_US         302
`define PROG_SLOTS           18
`define NOMINAL_REPLY_CYCLES ((`NOMINAL_REPLY_NS * 1000) / `CLK_PERIOD_PS)
`define PROG_CYCLES ((`PROG_SLOTS * `PROG_SLOT_US * 1000000) / `CLK_PERIOD_PS)
`endif

// *** rtl/vtag_pkg.sv ***
package vtag_pkg;
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_RECV    = 4'b0001,
    ST_DECODE  = 4'b0010,
    ST_PROGRAM = 4'b0011,
    ST_DELAY   = 4'b0100,
    ST_SEND    = 4'b0101,
    ST_CRC_LO  = 4'b0110,
    ST_CRC_HI  = 4'b0111,
    ST_DONE    = 4'b1000
  } ctrl_state_t;
  typedef enum logic [1:0] {
    TAG_READY    = 2'b00,
    TAG_SELECTED = 2'b01,
    TAG_QUIET    = 2'b10
  } tag_state_t;
endpackage

// *** rtl/crc16_unit.sv ***
`timescale 1ns/1ps
`include "vtag_consts.svh"
// byte-wide reflected crc16, preset on clear
module crc16_unit (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // control
  input  wire logic        clear,
  input  wire logic        feed,
  input  wire logic [7:0]  data,
  // result
  output logic      [15:0] crc
);
  logic [15:0] next_crc;

  // eight shifts of the reflected polynomial per byte
  always_comb begin
    next_crc = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      if (next_crc[0]) begin
        next_crc = (next_crc >> 1) ^ `CRC_POLY_REV;
      end else begin
        next_crc = next_crc >> 1;
      end
    end
  end

  // crc register
  always_ff @(posedge ref_clk) begin
    if (!reset_n || clear) begin
      crc <= `CRC_PRESET;
    end else if (feed) begin
      crc <= next_crc;
    end
  end
endmodule // crc16_unit

// *** rtl/sync_edge.sv ***
`timescale 1ns/1ps
// two-flop synchroniser with a rising edge pulse
module sync_edge (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // async in, synced out
  input  wire logic din,
  output logic      level,
  output logic      rise
);
  logic meta;
  logic last;

  // double flop then edge history
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      meta  <= 1'b0;
      level <= 1'b0;
      last  <= 1'b0;
    end else begin
      meta  <= din;
      level <= meta;
      last  <= level;
    end
  end

  assign rise = level & ~last;
endmodule // sync_edge

// *** rtl/vicinity_tag_cmd_handler.sv ***
`timescale 1ns/1ps
`include "vtag_consts.svh"
// command handler: request bytes in on the link clock, reply bytes out
module vicinity_tag_cmd_handler #(
  parameter int PROG_CYCLES  = `PROG_CYCLES,
  parameter int REPLY_CYCLES = `NOMINAL_REPLY_CYCLES
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // decoded request stream, sampled on link clock rising edge
  input  wire logic             link_clk,
  input  wire logic             rx_frame,
  input  wire logic             rx_valid,
  input  wire logic [7:0]       rx_byte,
  // response stream
  output logic                  tx_frame,
  output logic                  tx_valid,
  output logic      [7:0]       tx_byte,
  input  wire logic             tx_ready,
  // identity and memory
  input  wire logic [63:0]      own_uid,
  output logic      [5:0]       mem_addr,
  input  wire logic [31:0]      mem_rdata,
  input  wire logic             mem_locked,
  output logic                  afi_prog,
  output logic      [7:0]       afi_wdata,
  output logic                  afi_lock_prog,
  input  wire logic             prog_ok,
  input  wire logic             afi_locked,
  // status
  output vtag_pkg::tag_state_t  tag_state,
  output logic      [7:0]       afi_value
);
  import vtag_pkg::*;

  ctrl_state_t st;
  logic [7:0]  req [0:13];
  logic [3:0]  rx_cnt;
  logic        lclk_lvl, lclk_rise, frm_lvl, vld_lvl;
  logic [7:0]  meta_b, rx_b;
  logic        crc_clear, crc_feed;
  logic [7:0]  crc_data;
  logic [15:0] crc;
  logic [31:0] wait_cnt;
  logic [7:0]  err_code, cmd, flags, afi_arg;
  logic        is_err, addressed, opt, uid_ok;
  logic [5:0]  blk;
  logic [6:0]  blk_left;
  logic [2:0]  byte_idx;
  logic        frm_last, frm_end;
  logic [3:0]  pos;
  logic [1:0]  lane;
  logic        uid_pass;

  // ============================================================
  // link sampling
  sync_edge u_clk (.ref_clk(ref_clk), .reset_n(reset_n), .din(link_clk),
                   .level(lclk_lvl), .rise(lclk_rise));
  sync_edge u_frm (.ref_clk(ref_clk), .reset_n(reset_n), .din(rx_frame),
                   .level(frm_lvl), .rise());
  sync_edge u_vld (.ref_clk(ref_clk), .reset_n(reset_n), .din(rx_valid),
                   .level(vld_lvl), .rise());

  // data byte double flop
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      meta_b <= 8'h00;
      rx_b   <= 8'h00;
    end else begin
      meta_b <= rx_byte;
      rx_b   <= meta_b;
    end
  end

  // ============================================================
  // decode helpers
  assign flags     = req[0];
  assign cmd       = req[1];
  assign addressed = flags[`FLAG_ADDRESS_BIT];
  assign opt       = flags[`FLAG_OPTION_BIT];
  assign pos       = addressed ? 4'hA : 4'h2;
  assign uid_ok    = {req[9], req[8], req[7], req[6], req[5], req[4],
                      req[3], req[2]} == own_uid;
  assign afi_arg   = req[pos];
  assign frm_end   = frm_last & ~frm_lvl;
  // select carries its own uid test, so it passes here
  assign uid_pass  = (cmd == `CMD_SELECT) || !addressed || uid_ok;
  // data lane: a lock byte shifts the word by one position
  assign lane      = byte_idx[1:0] - {1'b0, opt};

  // crc unit shared by receive and transmit
  crc16_unit u_crc (.ref_clk(ref_clk), .reset_n(reset_n),
                    .clear(crc_clear), .feed(crc_feed), .data(crc_data),
                    .crc(crc));

  assign crc_clear = (st == ST_IDLE) || (st == ST_DECODE);
  assign crc_feed  = (st == ST_RECV && lclk_rise && vld_lvl) ||
                     (st == ST_SEND && tx_valid && tx_ready);
  assign crc_data  = (st == ST_RECV) ? rx_b : tx_byte;

  // ============================================================
  // frame edge history
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      frm_last <= 1'b0;
    end else begin
      frm_last <= frm_lvl;
    end
  end

  // main sequencer
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st            <= ST_IDLE;
      rx_cnt        <= 4'h0;
      tx_frame      <= 1'b0;
      tx_valid      <= 1'b0;
      tx_byte       <= 8'h00;
      wait_cnt      <= 32'h0;
      err_code      <= 8'h00;
      is_err        <= 1'b0;
      blk           <= 6'h00;
      blk_left      <= 7'h00;
      byte_idx      <= 3'h0;
      mem_addr      <= 6'h00;
      afi_prog      <= 1'b0;
      afi_lock_prog <= 1'b0;
      afi_wdata     <= 8'h00;
      afi_value     <= 8'h00;
      tag_state     <= TAG_READY;
      for (int i = 0; i < 14; i++) begin
        req[i] <= 8'h00;
      end
    end else begin
      afi_prog      <= 1'b0;
      afi_lock_prog <= 1'b0;
      case (st)
        ST_IDLE: begin
          // wait for a request frame
          rx_cnt <= 4'h0;
          if (frm_lvl) begin
            st <= ST_RECV;
          end
        end
        ST_RECV: begin
          // capture on each synced link clock rise
          if (lclk_rise && vld_lvl && rx_cnt != 4'hE) begin
            req[rx_cnt] <= rx_b;
            rx_cnt      <= rx_cnt + 4'h1;
          end
          if (frm_end) begin
            st <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          // residue check rejects bad frames silently
          st       <= ST_IDLE;
          is_err   <= 1'b0;
          err_code <= 8'h00;
          wait_cnt <= 32'(REPLY_CYCLES);
          blk      <= req[pos][5:0];
          mem_addr <= req[pos][5:0];
          blk_left <= 7'(req[pos + 4'h1][5:0]) + 7'h1;
          byte_idx <= 3'h0;
          if (crc == `CRC_RESIDUE && uid_pass) begin
            case (cmd)
              `CMD_READ_MULTI: begin
                st <= ST_DELAY;
                // first block and count range checks
                if (req[pos][7:6] != 2'b00) begin
                  is_err   <= 1'b1;
                  err_code <= `ERR_NO_BLOCK;
                end else if (req[pos + 4'h1][7:6] != 2'b00) begin
                  is_err   <= 1'b1;
                  err_code <= `ERR_OTHER;
                end
              end
              `CMD_SELECT: begin
                // mismatch drops a selected tag silently
                if (uid_ok) begin
                  tag_state <= TAG_SELECTED;
                  st        <= ST_DELAY;
                end else if (tag_state == TAG_SELECTED) begin
                  tag_state <= TAG_READY;
                end
              end
              `CMD_RESET_READY: begin
                tag_state <= TAG_READY;
                st        <= ST_DELAY;
              end
              `CMD_WRITE_AFI: begin
                // refuse when locked, else start programming
                if (afi_locked) begin
                  is_err   <= 1'b1;
                  err_code <= `ERR_LOCKED;
                  st       <= ST_DELAY;
                end else begin
                  afi_prog  <= 1'b1;
                  afi_wdata <= afi_arg;
                  wait_cnt  <= 32'(PROG_CYCLES);
                  st        <= ST_PROGRAM;
                end
              end
              `CMD_LOCK_AFI: begin
                // an existing lock is refused up front
                if (afi_locked) begin
                  is_err   <= 1'b1;
                  err_code <= `ERR_LOCKED_ALR;
                  st       <= ST_DELAY;
                end else begin
                  afi_lock_prog <= 1'b1;
                  wait_cnt      <= 32'(PROG_CYCLES);
                  st            <= ST_PROGRAM;
                end
              end
              default: st <= ST_IDLE;
            endcase
          end
        end
        ST_PROGRAM: begin
          // reader keeps the field quiet here
          if (wait_cnt <= 32'h1) begin
            wait_cnt <= 32'(REPLY_CYCLES);
            st       <= ST_DELAY;
            if (!prog_ok) begin
              is_err   <= 1'b1;
              err_code <= (cmd == `CMD_WRITE_AFI) ? `ERR_NOT_PROG
                                                  : `ERR_NOT_LOCKED;
            end else if (cmd == `CMD_WRITE_AFI) begin
              afi_value <= afi_wdata;
            end
          end else begin
            wait_cnt <= wait_cnt - 32'h1;
          end
        end
        ST_DELAY: begin
          // reply delay, then the flags byte opens the frame
          if (wait_cnt <= 32'h1) begin
            st       <= ST_SEND;
            tx_frame <= 1'b1;
            tx_valid <= 1'b1;
            tx_byte  <= is_err ? `RESP_ERR : `RESP_OK;
            byte_idx <= is_err ? 3'h6 : 3'h0;
          end else begin
            wait_cnt <= wait_cnt - 32'h1;
          end
        end
        ST_SEND: begin
          // payload bytes advance on each accepted cycle
          if (tx_valid && tx_ready) begin
            if (byte_idx == 3'h6) begin
              // error code follows the flags byte
              tx_byte  <= err_code;
              byte_idx <= 3'h7;
            end else if (cmd != `CMD_READ_MULTI || is_err ||
                         blk_left == 7'h0) begin
              // one idle cycle lets the crc take the last byte
              st       <= ST_CRC_LO;
              tx_valid <= 1'b0;
            end else if (byte_idx == 3'h0 && opt) begin
              tx_byte  <= {7'h00, mem_locked};
              byte_idx <= 3'h1;
            end else begin
              tx_byte  <= mem_rdata[{lane, 3'b000} +: 8];
              if (byte_idx == 3'h4 || (byte_idx == 3'h3 && !opt)) begin
                // six-bit address rolls over past the last block
                byte_idx <= 3'h0;
                blk_left <= blk_left - 7'h1;
                blk      <= blk + 6'h1;
                mem_addr <= blk + 6'h1;
              end else begin
                byte_idx <= byte_idx + 3'h1;
              end
            end
          end
        end
        ST_CRC_LO: begin
          // crc now covers every reply byte
          tx_byte  <= ~crc[7:0];
          tx_valid <= 1'b1;
          st       <= ST_CRC_HI;
        end
        ST_CRC_HI: begin
          // high byte once the low byte is taken
          if (tx_ready) begin
            tx_byte <= ~crc[15:8];
            st      <= ST_DONE;
          end
        end
        ST_DONE: begin
          // close the frame once the high byte is taken
          if (tx_ready) begin
            tx_valid <= 1'b0;
            tx_frame <= 1'b0;
            st       <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end
endmodule // vicinity_tag_cmd_handler

// *** tb/vtag_reader.sv ***
`timescale 1ns/1ps
`include "vtag_consts.svh"
// ============================================================
// reader model: request frames on a 48 ns link clock
module vtag_reader (
  // link to the tag
  output logic       link_clk,
  output logic       rx_frame,
  output logic       rx_valid,
  output logic [7:0] rx_byte
);
  // reflected crc16, complemented
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = `CRC_PRESET;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ `CRC_POLY_REV) : (c >> 1);
      end
    end
    return ~c;
  endfunction
  // idle link: clock still, no frame
  initial begin
    link_clk = 1'b0;
    rx_frame = 1'b0;
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
  end
  // one frame, crc lo then hi; bad flips a crc bit
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    rx_frame = 1'b1;
    #24;
    foreach (q[i]) begin
      rx_byte  = q[i];
      rx_valid = 1'b1;
      #12 link_clk = 1'b1;
      #24 link_clk = 1'b0;
      #12;
    end
    rx_valid = 1'b0;
    rx_frame = 1'b0;
    rx_byte  = ~rx_byte; // released line shows no stale byte
  endtask
endmodule // vtag_reader

// *** tb/vtag_checker.sv ***
`timescale 1ns/1ps
`include "vtag_consts.svh"
// ============================================================
// port checker for the command handler
module vtag_checker #(
  parameter int PROG_CYCLES = 20
) (
  // clock and reset
  input wire logic                 ref_clk,
  input wire logic                 reset_n,
  // observed ports
  input wire logic                 rx_frame,
  input wire logic                 tx_frame,
  input wire logic                 tx_valid,
  input wire logic [7:0]           tx_byte,
  input wire logic                 tx_ready,
  input wire logic                 afi_prog,
  input wire logic                 afi_lock_prog,
  input wire logic                 afi_locked
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [31:0] since;
  // cycles since the last programming pulse
  always_ff @(posedge ref_clk) begin
    if (!reset_n || afi_prog || afi_lock_prog) begin
      since <= '0;
    end else if (since != 32'hFFFF_FFFF) begin
      since <= since + 32'h1;
    end
  end
  sequence quiet_s;
    !tx_frame [*8];
  endsequence
  sequence flags_s;
    tx_valid && (tx_byte == `RESP_OK || tx_byte == `RESP_ERR);
  endsequence
  a_valid_in_frame: assert property (tx_valid |-> tx_frame)
    else $error("reply byte outside frame");
  a_quiet_after_req: assert property ($fell(rx_frame) |-> quiet_s)
    else $error("reply too early");
  a_first_is_flags: assert property ($rose(tx_frame) |-> flags_s)
    else $error("reply does not open with flags");
  a_byte_stands: assert property
    (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("reply byte dropped while stalled");
  a_prog_pulse: assert property (afi_prog |=> !afi_prog)
    else $error("program pulse too long");
  a_lock_pulse: assert property (afi_lock_prog |=> !afi_lock_prog)
    else $error("lock pulse too long");
  a_prog_refused: assert property (afi_prog |-> !afi_locked)
    else $error("write started on locked value");
  a_lock_refused: assert property (afi_lock_prog |-> !afi_locked)
    else $error("lock started when already locked");
  a_reply_after_prog: assert property
    ($rose(tx_frame) |-> since >= PROG_CYCLES)
    else $error("reply inside program cycle");
endmodule // vtag_checker
bind vicinity_tag_cmd_handler vtag_checker #(.PROG_CYCLES(PROG_CYCLES))
  vtag_checker_i (.ref_clk(ref_clk), .reset_n(reset_n),
  .rx_frame(rx_frame), .tx_frame(tx_frame), .tx_valid(tx_valid),
  .tx_byte(tx_byte), .tx_ready(tx_ready), .afi_prog(afi_prog),
  .afi_lock_prog(afi_lock_prog), .afi_locked(afi_locked));

// *** tb/vicinity_tag_cmd_handler_tb.sv ***
`timescale 1ns/1ps
`include "vtag_consts.svh"
// ============================================================
// bench: reader model, memory model, reply checks
module vicinity_tag_cmd_handler_tb;
  import vtag_pkg::*;
  logic        ref_clk, reset_n, link_clk, rx_frame, rx_valid, tx_frame;
  logic        tx_valid, tx_ready, mem_locked, afi_prog, afi_lock_prog;
  logic        prog_ok, afi_locked;
  logic [7:0]  rx_byte, tx_byte, afi_wdata, afi_value;
  logic [5:0]  mem_addr;
  logic [31:0] mem_rdata;
  logic [63:0] own_uid, lock_mask;
  tag_state_t  tag_state;
  logic [7:0]  rq[$], q[$], e[$];
  int          errors, n_checks;
  vicinity_tag_cmd_handler #(.PROG_CYCLES(20), .REPLY_CYCLES(10))
    vicinity_tag_cmd_handler_i (.ref_clk, .reset_n, .link_clk, .rx_frame,
    .rx_valid, .rx_byte, .tx_frame, .tx_valid, .tx_byte, .tx_ready,
    .own_uid, .mem_addr, .mem_rdata, .mem_locked, .afi_prog, .afi_wdata,
    .afi_lock_prog, .prog_ok, .afi_locked, .tag_state, .afi_value);
  vtag_reader vtag_reader_i (.link_clk, .rx_frame, .rx_valid, .rx_byte);
  // memory: data pattern from address, lock bits from a mask
  function automatic logic [31:0] dw(input logic [5:0] a);
    return {2'b01, a, 8'hA5, 2'b10, a, 8'h3C};
  endfunction
  assign mem_rdata  = dw(mem_addr);
  assign mem_locked = lock_mask[mem_addr];
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // reply bytes taken on accepted cycles; consumer stalls at random
  always @(posedge ref_clk) begin
    if (tx_valid === 1'b1 && tx_ready) rq.push_back(tx_byte);
    #1 tx_ready = ($urandom_range(3) != 0);
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // request head: flags, command, uid lsb first when addressed
  task automatic head(input logic [7:0] fl, input logic [7:0] cmd,
                      input logic [63:0] uid);
    q = {fl, cmd};
    for (int i = 0; i < 8 && fl[`FLAG_ADDRESS_BIT]; i++) begin
      q.push_back(uid[8*i+:8]);
    end
  endtask
  // send q, wait for the reply, compare against e plus crc
  task automatic xact(input logic bad);
    logic        seen;
    logic [15:0] c;
    seen = 1'b0;
    rq = {};
    vtag_reader_i.send(q, bad);
    for (int i = 0; i < 1500 && !(seen && !tx_frame); i++) begin
      @(posedge ref_clk);
      seen |= (tx_frame === 1'b1);
    end
    #1;
    if (tx_frame !== 1'b0 || (!seen && e.size() > 0)) begin
      errors++;
      end_of_test();
    end
    if (e.size() > 0) begin
      c = vtag_reader_i.crc16(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    check(32'(rq.size()), 32'(e.size()));
    foreach (e[i]) check({24'h0, rq[i]}, {24'h0, e[i]});
    $display("command %0h done, %0d reply bytes", q[1], rq.size());
  endtask
  initial begin
    logic [7:0] v, f8, c8, fl;
    logic [5:0] a;
    logic [31:0] d;
    reset_n = 1'b0;
    prog_ok = 1'b1;
    afi_locked = 1'b0;
    errors = 0;
    n_checks = 0;
    void'($urandom(32'h2E96));
    own_uid = {$urandom, $urandom};
    lock_mask = {$urandom, $urandom};
    repeat (3) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    // reads: seven blocks, wrap with lock bytes, all 64, random
    for (int t = 0; t < 8; t++) begin
      fl = {1'b0, t[0], t[2], 5'b0};
      f8 = (t == 1) ? 8'd62 : 8'($urandom_range(63));
      c8 = (t == 0) ? 8'h06 : (t == 2) ? 8'd63 : 8'($urandom_range(63));
      head(fl, `CMD_READ_MULTI, own_uid);
      q.push_back(f8);
      q.push_back(c8);
      e = {`RESP_OK};
      for (int n = 0; n <= int'(c8); n++) begin
        a = f8[5:0] + 6'(n);
        d = dw(a);
        if (fl[6]) e.push_back({7'h0, lock_mask[a]});
        for (int k = 0; k < 4; k++) e.push_back(d[8*k+:8]);
      end
      xact(1'b0);
    end
    // read errors: too many blocks, block beyond memory
    for (int t = 0; t < 2; t++) begin
      head(8'h00, `CMD_READ_MULTI, own_uid);
      q.push_back(t ? 8'h40 : 8'h00);
      q.push_back(t ? 8'h00 : 8'h40);
      e = {`RESP_ERR, t ? `ERR_NO_BLOCK : `ERR_OTHER};
      xact(1'b0);
    end
    // select own uid, then another: silent fall back to ready
    head(8'h20, `CMD_SELECT, own_uid);
    e = {`RESP_OK};
    xact(1'b0);
    check(tag_state, TAG_SELECTED);
    head(8'h20, `CMD_SELECT, ~own_uid);
    e = {};
    xact(1'b0);
    check(tag_state, TAG_READY);
    // reset to ready: other uid ignored, own and broadcast answered
    head(8'h20, `CMD_SELECT, own_uid);
    e = {`RESP_OK};
    xact(1'b0);
    for (int t = 0; t < 3; t++) begin
      head(t == 2 ? 8'h00 : 8'h20, `CMD_RESET_READY, t ? own_uid : ~own_uid);
      e = {};
      if (t) e.push_back(`RESP_OK);
      xact(1'b0);
    end
    check(tag_state, TAG_READY);
    // afi write then lock: success, failed programming, locked
    for (int t = 0; t < 6; t++) begin
      v = 8'($urandom);
      prog_ok = (t % 3 != 1);
      afi_locked = (t % 3 == 2);
      head(8'h00, t < 3 ? `CMD_WRITE_AFI : `CMD_LOCK_AFI, own_uid);
      if (t < 3) q.push_back(v);
      e = {(t % 3) ? `RESP_ERR : `RESP_OK};
      if (t % 3) e.push_back(t == 1 ? `ERR_NOT_PROG : t == 2 ? `ERR_LOCKED :
                             t == 4 ? `ERR_NOT_LOCKED : `ERR_LOCKED_ALR);
      xact(1'b0);
      if (t == 0) check(afi_value, v);
      if (t == 0) check(afi_wdata, v);
    end
    // corrupted crc: no answer
    head(8'h00, `CMD_READ_MULTI, own_uid);
    q.push_back(8'h00);
    q.push_back(8'h00);
    e = {};
    xact(1'b1);
    end_of_test();
  end
endmodule // vicinity_tag_cmd_handler_tb
